// ===== irq_ctrl_params.svh
// register offsets, field positions and reset values for the interrupt slice
`ifndef IRQ_CTRL_PARAMS_SVH
`define IRQ_CTRL_PARAMS_SVH
`define OFS_IRQ_ENABLE_CTRL_1 12'h000
`define OFS_IRQ_PRIORITY_CTRL_15 12'h004
`define OFS_IRQ_PRIORITY_CTRL_16 12'h008
`define OFS_CORE_CTRL 12'h00C
`define OFS_CORE_STATUS 12'h010
`define IRQ_ENABLE_CTRL_1_IMPL_MASK 16'h20DB
`define IRQ_PRIORITY_CTRL_15_IMPL_MASK 16'h7000
`define IRQ_PRIORITY_CTRL_16_IMPL_MASK 16'h0070
`define IRQ_PRIORITY_CTRL_15_RESET 16'h4000
`define IRQ_PRIORITY_CTRL_16_RESET 16'h0040
`define IRQ_ENABLE_CTRL_1_RESET 16'h0000
`define BIT_EXT_IRQ2 13
`define BIT_CAPTURE8 7
`define BIT_CAPTURE7 6
`define BIT_EXT_IRQ1 4
`define BIT_CHANGE_NOTIFY 3
`define BIT_I2C_MASTER 1
`define BIT_I2C_SLAVE 0
`define PWM_FAULT_A_LSB 12
`define UART_ERROR_LSB 4
`define ALT_TABLE_SELECT_BIT 15
`define RESET_PC 24'h000000
`endif

// ===== irq_ctrl_pkg.sv
// types shared by the interrupt slice
package irq_ctrl_pkg;
    typedef struct packed {
        logic [11:0] addr;
        logic write;
        logic [31:0] wdata;
    } apb_req_t;
    typedef logic [2:0] prio_t;
    typedef struct packed {
        logic valid;
        prio_t level;
        logic [3:0] source;
        logic alt_table;
    } core_irq_t;
    typedef enum logic [1:0] {ST_IDLE, ST_ACCESS} apb_state_t;
endpackage : irq_ctrl_pkg

// ===== reset_vector_irq_enable_priority.sv
// register slice of the interrupt controller and core reset entry logic
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctrl_params.svh"

module reset_vector_irq_enable_priority
    import irq_ctrl_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic clk_en_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [8:0] irq_req_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    output logic [8:0] irq_pass_o,
    output logic irq_valid_o,
    output logic [2:0] irq_level_o,
    output logic [3:0] irq_source_o,
    output logic alt_table_o,
    output logic [23:0] fetch_pc_o
);
    logic [15:0] enable_reg;
    logic [15:0] prio15_reg;
    logic [15:0] prio16_reg;
    logic alt_sel_reg;
    logic [23:0] pc_reg;
    logic [31:0] rdata_reg;
    logic ready_reg;
    logic err_reg;
    logic [8:0] pass_reg;
    core_irq_t irq_reg;
    core_irq_t irq_next;
    logic [8:0] gated;
    logic [2:0] src_prio [0:8];
    logic [15:0] wdata16;

    // bus decode
    wire logic setup_phase = psel_i && !penable_i;
    wire logic hit_iec = paddr_i == `OFS_IRQ_ENABLE_CTRL_1;
    wire logic hit_irq_priority_ctrl_15 = paddr_i == `OFS_IRQ_PRIORITY_CTRL_15;
    wire logic hit_irq_priority_ctrl_16 = paddr_i == `OFS_IRQ_PRIORITY_CTRL_16;
    wire logic hit_ctrl = paddr_i == `OFS_CORE_CTRL;
    wire logic hit_stat = paddr_i == `OFS_CORE_STATUS;
    wire logic mapped = hit_iec || hit_irq_priority_ctrl_15 || hit_irq_priority_ctrl_16 || hit_ctrl || hit_stat;
    wire logic do_write = setup_phase && pwrite_i && mapped;
    assign wdata16 = pwdata_i[15:0];

    // per-source priority: only the two sources with fields here have one
    // sources without a field default to level 1
    genvar gi;
    generate
        for (gi = 0; gi < 9; gi = gi + 1)
        begin : g_src
            if (gi == 7)
            begin : g_flt
                assign src_prio[gi] = prio15_reg[`PWM_FAULT_A_LSB +: 3];
            end
            else if (gi == 8)
            begin : g_uart
                assign src_prio[gi] = prio16_reg[`UART_ERROR_LSB +: 3];
            end
            else
            begin : g_def
                assign src_prio[gi] = 3'h1;
            end
            // enable gates requests 0 to 6 only; zero priority blocks any request
            if (gi < 7)
            begin : g_en
                localparam int BITPOS = (gi == 0) ? `BIT_I2C_SLAVE :
                    (gi == 1) ? `BIT_I2C_MASTER : (gi == 2) ? `BIT_CHANGE_NOTIFY :
                    (gi == 3) ? `BIT_EXT_IRQ1 : (gi == 4) ? `BIT_CAPTURE7 :
                    (gi == 5) ? `BIT_CAPTURE8 : `BIT_EXT_IRQ2;
                assign gated[gi] = irq_req_i[gi] && enable_reg[BITPOS] && (src_prio[gi] != 3'h0);
            end
            else
            begin : g_noen
                assign gated[gi] = irq_req_i[gi] && (src_prio[gi] != 3'h0);
            end
        end
    endgenerate

    // highest level wins; lowest index breaks ties
    // field value is the level
    always_comb
    begin
        irq_next = '0;
        irq_next.alt_table = alt_sel_reg;
        for (int i = 8; i >= 0; i--)
        begin
            if (gated[i] && (!irq_next.valid || src_prio[i] >= irq_next.level))
            begin
                irq_next.valid = 1'b1;
                irq_next.level = src_prio[i];
                irq_next.source = 4'(i);
            end
        end
    end

    wire logic [31:0] read_mux =
        hit_iec ? {16'h0000, enable_reg} :
        hit_irq_priority_ctrl_15 ? {16'h0000, prio15_reg} :
        hit_irq_priority_ctrl_16 ? {16'h0000, prio16_reg} :
        hit_ctrl ? {16'h0000, alt_sel_reg, 15'h0000} :
        hit_stat ? {8'h00, pc_reg} : 32'h0000_0000;

    // reset loads the register reset values directly, no vector involved
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            enable_reg <= `IRQ_ENABLE_CTRL_1_RESET;
            prio15_reg <= `IRQ_PRIORITY_CTRL_15_RESET;
            prio16_reg <= `IRQ_PRIORITY_CTRL_16_RESET;
            alt_sel_reg <= 1'b0;
        end
        else if (clk_en_i && do_write)
        begin
            if (hit_iec)
                enable_reg <= wdata16 & `IRQ_ENABLE_CTRL_1_IMPL_MASK;
            if (hit_irq_priority_ctrl_15)
                prio15_reg <= wdata16 & `IRQ_PRIORITY_CTRL_15_IMPL_MASK;
            if (hit_irq_priority_ctrl_16)
                prio16_reg <= wdata16 & `IRQ_PRIORITY_CTRL_16_IMPL_MASK;
            if (hit_ctrl)
                alt_sel_reg <= wdata16[`ALT_TABLE_SELECT_BIT];
        end
    end

    // one wait-free access phase: answer ready in the access cycle
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            rdata_reg <= 32'h0000_0000;
            ready_reg <= 1'b0;
            err_reg <= 1'b0;
        end
        else if (clk_en_i)
        begin
            ready_reg <= setup_phase;
            err_reg <= setup_phase && !mapped;
            rdata_reg <= (setup_phase && !pwrite_i) ? read_mux : 32'h0000_0000;
        end
    end

    // fetch counter starts at zero and steps by two
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
            pc_reg <= `RESET_PC;
        else if (clk_en_i)
            pc_reg <= pc_reg + 24'h000002;
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            pass_reg <= 9'h000;
            irq_reg <= '0;
        end
        else if (clk_en_i)
        begin
            pass_reg <= gated;
            irq_reg <= irq_next;
        end
    end

    assign prdata_o = rdata_reg;
    assign pready_o = ready_reg;
    assign pslverr_o = err_reg;
    assign irq_pass_o = pass_reg;
    assign irq_valid_o = irq_reg.valid;
    assign irq_level_o = irq_reg.level;
    assign irq_source_o = irq_reg.source;
    assign alt_table_o = irq_reg.alt_table;
    assign fetch_pc_o = pc_reg;

    property p_reset_pc;
        @(posedge sys_clk_i) reset_i |=> (fetch_pc_o == 24'h000000);
    endproperty
    reset_pc_start_a : assert property (p_reset_pc)
        else $error("fetch address not zero after reset");

    reset_clears_irq_a : assert property (
        @(posedge sys_clk_i) reset_i |=> !irq_valid_o && irq_pass_o == 9'h000)
        else $error("request forwarded during reset");

    reset_values_a : assert property (
        @(posedge sys_clk_i) reset_i |=> enable_reg == 16'h0000 && prio15_reg == 16'h4000
            && prio16_reg == 16'h0040 && !alt_sel_reg)
        else $error("registers not at reset values");

    enable_layout_a : assert property (
        @(posedge sys_clk_i) disable iff (reset_i) (enable_reg & 16'hDF24) == 16'h0000)
        else $error("enable register holds an unimplemented bit");

    sequence s_blocked;
        !enable_reg[`BIT_EXT_IRQ2] && irq_req_i[6] && clk_en_i;
    endsequence
    enable_gate_a : assert property (
        @(posedge sys_clk_i) disable iff (reset_i) s_blocked |=> !irq_pass_o[6])
        else $error("disabled request reached the core");

    level_direct_a : assert property (
        @(posedge sys_clk_i) disable iff (reset_i)
            irq_valid_o && irq_source_o == 4'h7 |-> irq_level_o == $past(prio15_reg[14:12]))
        else $error("level does not match priority field");

    fault_field_a : assert property (
        @(posedge sys_clk_i) disable iff (reset_i)
            clk_en_i && do_write && hit_irq_priority_ctrl_15 |=> prio15_reg[14:12] == $past(pwdata_i[14:12]))
        else $error("fault priority write lost");

    uart_field_a : assert property (
        @(posedge sys_clk_i) disable iff (reset_i)
            clk_en_i && do_write && hit_irq_priority_ctrl_16 |=> prio16_reg == ($past(pwdata_i[15:0]) & 16'h0070))
        else $error("uart priority write wrong");

    sequence s_read15;
        setup_phase && !pwrite_i && hit_irq_priority_ctrl_15 && clk_en_i;
    endsequence
    unimpl_zero_a : assert property (
        @(posedge sys_clk_i) disable iff (reset_i) s_read15 |=> (prdata_o & 32'hFFFF8FFF) == 0)
        else $error("unimplemented bits read nonzero");

    prio_zero_block_a : assert property (
        @(posedge sys_clk_i) disable iff (reset_i)
            clk_en_i && prio16_reg[6:4] == 3'h0 |=> !irq_pass_o[8])
        else $error("zero priority source forwarded");

    alt_follow_a : assert property (
        @(posedge sys_clk_i) disable iff (reset_i) clk_en_i |=> alt_table_o == $past(alt_sel_reg))
        else $error("alternate table select not followed");
endmodule : reset_vector_irq_enable_priority
`default_nettype wire

// ===== irq_source_model.sv
// request source model driving the interrupt request lines
`timescale 1ns/1ps
`default_nettype none
module irq_source_model
(
    input wire logic clk_i,
    input wire logic [8:0] raise_i,
    output logic [8:0] irq_req_o
);
    // vector contents are software's; the model only raises requests
    always_ff @(posedge clk_i)
    begin
        irq_req_o <= raise_i;
    end
endmodule : irq_source_model
`default_nettype wire

// ===== reset_vector_irq_enable_priority_bench.sv
// self-checking bench for the interrupt register slice
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctrl_params.svh"
module reset_vector_irq_enable_priority_bench;
    logic sys_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic clk_en = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [8:0] pattern = 9'h000;
    logic [8:0] irq_req;
    logic [31:0] prdata;
    logic pready, pslverr, irq_valid, alt_table;
    logic [8:0] irq_pass;
    logic [2:0] irq_level;
    logic [3:0] irq_source;
    logic [23:0] fetch_pc;
    logic [31:0] rd;
    logic er;
    int n_mismatch = 0;
    int n_tests = 0;
    int cycles = 0;
    int bitpos[7] = '{0, 1, 3, 4, 6, 7, 13};
    always #4 sys_clk_i = ~sys_clk_i;
    irq_source_model i_irq_source_model (.clk_i(sys_clk_i), .raise_i(pattern),
        .irq_req_o(irq_req));
    reset_vector_irq_enable_priority i_reset_vector_irq_enable_priority (
        .sys_clk_i(sys_clk_i), .reset_i(reset_i), .clk_en_i(clk_en), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .irq_req_i(irq_req), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .irq_pass_o(irq_pass), .irq_valid_o(irq_valid), .irq_level_o(irq_level),
        .irq_source_o(irq_source), .alt_table_o(alt_table), .fetch_pc_o(fetch_pc));
    task automatic summarize;
        $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : summarize
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            $display("unexpected %s expected %h seen %h", nm, exp, got);
            n_mismatch++;
        end
    endtask : chk
    // setup cycle, access until pready; answer taken mid-cycle, released after the pready edge
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge sys_clk_i);
        penable <= 1'b1;
        do @(negedge sys_clk_i); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        @(posedge sys_clk_i);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk_i);
    endtask : apb
    task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
        apb(a, 1'b0, 32'h0);
        chk($sformatf("reg %h", a), exp, rd);
    endtask : rchk
    task automatic settle;
        repeat (3) @(posedge sys_clk_i);
    endtask : settle
    task automatic reset_entry;
        reset_i <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        @(negedge sys_clk_i);
        chk("fetch_pc", 32'h0, {8'h00, fetch_pc});
        chk("irq_valid", 32'h0, {31'h0, irq_valid});
        chk("alt_table", 32'h0, {31'h0, alt_table});
        @(posedge sys_clk_i);
        rchk(`OFS_IRQ_ENABLE_CTRL_1, 32'h0000);
        rchk(`OFS_IRQ_PRIORITY_CTRL_15, 32'h4000);
        rchk(`OFS_IRQ_PRIORITY_CTRL_16, 32'h0040);
    endtask : reset_entry
    task automatic reserved_bits;
        apb(`OFS_IRQ_ENABLE_CTRL_1, 1'b1, 32'hFFFFFFFF);
        apb(`OFS_IRQ_PRIORITY_CTRL_15, 1'b1, 32'hFFFFFFFF);
        apb(`OFS_IRQ_PRIORITY_CTRL_16, 1'b1, 32'hFFFFFFFF);
        rchk(`OFS_IRQ_ENABLE_CTRL_1, 32'h20DB);
        rchk(`OFS_IRQ_PRIORITY_CTRL_15, 32'h7000);
        rchk(`OFS_IRQ_PRIORITY_CTRL_16, 32'h0070);
        apb(12'h020, 1'b0, 32'h0);
        chk("pslverr", 32'h1, {31'h0, er});
    endtask : reserved_bits
    task automatic gating;
        pattern <= 9'h1FF;
        for (int i = 0; i < 7; i++)
        begin
            apb(`OFS_IRQ_ENABLE_CTRL_1, 1'b1, 32'h1 << bitpos[i]);
            settle();
            chk("irq_pass", 32'h180 | (32'h1 << i), {23'h0, irq_pass});
        end
        apb(`OFS_IRQ_ENABLE_CTRL_1, 1'b1, 32'h0);
        apb(`OFS_IRQ_PRIORITY_CTRL_16, 1'b1, 32'h0050);
        settle();
        chk("irq_pass", 32'h180, {23'h0, irq_pass});
        chk("irq_source", 32'h7, {28'h0, irq_source});
        apb(`OFS_IRQ_PRIORITY_CTRL_15, 1'b1, 32'h0);
        settle();
        chk("irq_pass", 32'h100, {23'h0, irq_pass});
        chk("irq_source", 32'h8, {28'h0, irq_source});
        for (int l = 1; l < 8; l++)
        begin
            apb(`OFS_IRQ_PRIORITY_CTRL_16, 1'b1, l << 4);
            settle();
            chk("irq_level", l, {29'h0, irq_level});
        end
    endtask : gating
    task automatic alt_and_pc;
        logic [23:0] p;
        apb(`OFS_CORE_CTRL, 1'b1, 32'h8000);
        chk("alt_table", 32'h1, {31'h0, alt_table});
        @(negedge sys_clk_i);
        p = fetch_pc;
        repeat (4) @(negedge sys_clk_i);
        chk("fetch_pc step", {8'h00, p + 24'h8}, {8'h00, fetch_pc});
        @(posedge sys_clk_i);
        clk_en <= 1'b0;
        @(negedge sys_clk_i);
        p = fetch_pc;
        repeat (3) @(negedge sys_clk_i);
        chk("fetch_pc frozen", {8'h00, p}, {8'h00, fetch_pc});
        @(posedge sys_clk_i);
        clk_en <= 1'b1;
        @(posedge sys_clk_i);
    endtask : alt_and_pc
    always @(posedge sys_clk_i)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            n_mismatch++;
            summarize();
        end
    end
    initial
    begin
        reset_entry();
        reserved_bits();
        gating();
        alt_and_pc();
        reset_entry();
        summarize();
    end
endmodule : reset_vector_irq_enable_priority_bench
`default_nettype wire
